// [irmf_defs.svh]
// Notes on behaviour
// R01: each context shows a read-only 32-bit pointer to the first descriptor block fetched after its run bit 15 is set.
// R02: a packet with tag 11b, 10b, 01b or 00b is taken only while the tag enable at bit 31, 30, 29 or 28 is set.
// R03: match register bits 27 to 25 always read as zero, whatever is written.
// R04: bits 24 to 12 of the match register hold the start cycle as a 13-bit cycle count; the two low seconds bits must be 00b to match.
// R05: with control bit 29 set, a running context starts receiving only once the cycle timer equals the start cycle.
// R06: the 4-bit sync value in bits 11 to 8 is compared with each packet's sync field while the descriptor waits on 11b.
// R07: match register bit 7 always reads as zero.
// R08: with bit 6 and the tag 01b enable set, 01b packets are taken only if their sync field's two upper bits are 00b.
// R09: with bit 6 clear, packets are taken purely by the four tag enables.
// R10: a context takes only packets whose channel number equals the 6-bit field in bits 5 to 0.
// R11: with multi-channel bit 28 set, the channel field is ignored and every channel set in the channel mask is taken.
// R12: software must not change the multi-channel bit while the context is active or running.
// R13: pointer and match registers repeat for every context at a 32-byte stride from their base offsets.
`ifndef IRMF_DEFS_SVH
`define IRMF_DEFS_SVH

`define IRMF_PTR_BASE       16'h040c
`define IRMF_MATCH_BASE     16'h410c
`define IRMF_CTRL_BASE      16'h0400
`define IRMF_MASK_HI        16'h0070
`define IRMF_MASK_LO        16'h0078
`define IRMF_STRIDE         16'h0020

`define IRMF_TAG_BASE       28
`define IRMF_CM_HI          24
`define IRMF_CM_LO          12
`define IRMF_SYNC_HI        11
`define IRMF_SYNC_LO        8
`define IRMF_GATE_BIT       6
`define IRMF_CH_HI          5
`define IRMF_CH_LO          0
`define IRMF_MATCH_WMASK    32'hf1ff_ff7f

`define IRMF_CTRL_CME       29
`define IRMF_CTRL_MULTI     28
`define IRMF_CTRL_RUN       15
`define IRMF_CTRL_ACTIVE    10

`define IRMF_HDR_TAG_HI     15
`define IRMF_HDR_TAG_LO     14
`define IRMF_HDR_CH_HI      13
`define IRMF_HDR_CH_LO      8
`define IRMF_HDR_SY_HI      3
`define IRMF_HDR_SY_LO      0

`define IRMF_PTR_RESET      32'h0000_0000
`define IRMF_MATCH_RESET    32'h0000_0000
`define IRMF_MASK_RESET     32'h0000_0000

`endif

// [irmf_pkg.sv]
package irmf_pkg;
	typedef enum logic [1:0] {
		IRMF_IDLE,
		IRMF_PASS,
		IRMF_DROP
	} irmf_pkt_state_type;
endpackage

// [irmf_fifo.sv]
module irmf_fifo #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("irmf_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_valid = (wr_q != rd_q);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
		end else if (push) begin
			wr_q <= wr_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= '0;
		end else if (pop) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// [irmf_filter.sv]
// The implementer's own choice: the address-and-strobe port.
`include "irmf_defs.svh"

module irmf_filter #(
	parameter int CONTEXTS   = 4,
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic [15:0]            reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	input  wire logic [CONTEXTS-1:0]    ptr_load,
	input  wire logic [31:0]            ptr_load_value,
	input  wire logic [CONTEXTS-1:0]    desc_wait_sync,
	input  wire logic [6:0]             timer_seconds_field,
	input  wire logic [12:0]            timer_cycle_field,
	input  wire logic                   in_valid,
	output logic                        in_ready,
	input  wire logic                   in_first,
	input  wire logic                   in_last,
	input  wire logic [31:0]            in_data,
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic      [31:0]            out_data,
	output logic                        out_last,
	output logic      [((CONTEXTS > 1) ? $clog2(CONTEXTS) : 1)-1:0] out_ctx,
	output logic      [CONTEXTS-1:0]    ctx_active,
	output logic      [CONTEXTS-1:0]    sync_hit
);
	localparam int CTX_W  = (CONTEXTS > 1) ? $clog2(CONTEXTS) : 1;
	localparam int FIFO_W = 32 + 1 + CTX_W;

	if (CONTEXTS < 1 || CONTEXTS > 32) begin : g_chk
		$error("irmf_filter supports 1 to 32 contexts");
	end

	// context index behind an address, or -1 when none
	function automatic int ctx_of(input logic [15:0] addr, input logic [15:0] base);
		logic [15:0] off;
		off = addr - base;
		if (addr < base || off[4:0] != 5'h00 || int'(off[15:5]) >= CONTEXTS) begin
			return -1;
		end
		return int'(off[15:5]);
	endfunction

	logic [31:0] ptr_q   [CONTEXTS];
	logic [31:0] match_q [CONTEXTS];
	logic [CONTEXTS-1:0] run_q;
	logic [CONTEXTS-1:0] cme_q;
	logic [CONTEXTS-1:0] multi_q;
	logic [CONTEXTS-1:0] armed_q;
	logic [63:0]         mask_q;
	logic [31:0]         rdata_d;
	logic [31:0]         reg_rdata_q;
	logic [CONTEXTS-1:0] sync_hit_q;

	int wr_ptr_ctx;
	int wr_match_ctx;
	int wr_ctrl_ctx;
	int rd_ptr_ctx;
	int rd_match_ctx;
	int rd_ctrl_ctx;

	assign wr_ptr_ctx   = ctx_of(reg_addr, `IRMF_PTR_BASE);   // R13
	assign wr_match_ctx = ctx_of(reg_addr, `IRMF_MATCH_BASE); // R13
	assign wr_ctrl_ctx  = ctx_of(reg_addr, `IRMF_CTRL_BASE);
	assign rd_ptr_ctx   = wr_ptr_ctx;
	assign rd_match_ctx = wr_match_ctx;
	assign rd_ctrl_ctx  = wr_ctrl_ctx;

	// packet header fields of the first word
	logic [1:0] hdr_tag;
	logic [5:0] hdr_ch;
	logic [3:0] hdr_sy;

	assign hdr_tag = in_data[`IRMF_HDR_TAG_HI:`IRMF_HDR_TAG_LO];
	assign hdr_ch  = in_data[`IRMF_HDR_CH_HI:`IRMF_HDR_CH_LO];
	assign hdr_sy  = in_data[`IRMF_HDR_SY_HI:`IRMF_HDR_SY_LO];

	logic [CONTEXTS-1:0] accept;
	logic [CONTEXTS-1:0] sync_ok;

	for (genvar n = 0; n < CONTEXTS; n++) begin : g_ctx
		logic tag_ok;
		logic gate_ok;
		logic chan_ok;
		logic [14:0] start_cycle;

		assign start_cycle = 15'(match_q[n][`IRMF_CM_HI:`IRMF_CM_LO]); // R04
		assign tag_ok  = match_q[n][`IRMF_TAG_BASE + hdr_tag]; // R02
		// tag 01b filtered further on the sync field's upper bits
		assign gate_ok = !(match_q[n][`IRMF_GATE_BIT] && hdr_tag == 2'h1) // R08 R09
			|| (hdr_sy[3:2] == 2'h0); // R08
		assign chan_ok = multi_q[n] ? mask_q[hdr_ch] // R11
			: (hdr_ch == match_q[n][`IRMF_CH_HI:`IRMF_CH_LO]); // R10
		assign sync_ok[n] = !desc_wait_sync[n]
			|| (hdr_sy == match_q[n][`IRMF_SYNC_HI:`IRMF_SYNC_LO]); // R06
		assign accept[n] = run_q[n] && armed_q[n] && tag_ok && gate_ok && chan_ok && sync_ok[n];

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				ptr_q[n] <= `IRMF_PTR_RESET;
			end else if (ptr_load[n]) begin
				ptr_q[n] <= ptr_load_value; // R01
			end
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				match_q[n] <= `IRMF_MATCH_RESET;
			end else if (reg_wr && wr_match_ctx == n) begin
				match_q[n] <= reg_wdata & `IRMF_MATCH_WMASK; // R03 R07
			end
		end

		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				run_q[n]   <= 1'b0;
				cme_q[n]   <= 1'b0;
				multi_q[n] <= 1'b0;
			end else if (reg_wr && wr_ctrl_ctx == n) begin
				run_q[n]   <= reg_wdata[`IRMF_CTRL_RUN];
				cme_q[n]   <= reg_wdata[`IRMF_CTRL_CME];
				multi_q[n] <= reg_wdata[`IRMF_CTRL_MULTI];
			end
		end

		// start of reception, optionally held until the start cycle comes round
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				armed_q[n] <= 1'b0;
			end else if (!run_q[n]) begin
				armed_q[n] <= 1'b0;
			end else if (!cme_q[n]) begin
				armed_q[n] <= 1'b1;
			end else if ({timer_seconds_field[1:0], timer_cycle_field} == start_cycle) begin
				armed_q[n] <= 1'b1; // R05
			end
		end

		assign ctx_active[n] = run_q[n] && armed_q[n];
	end

	// channel mask for the multi-channel context
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= {`IRMF_MASK_RESET, `IRMF_MASK_RESET};
		end else if (reg_wr && reg_addr == `IRMF_MASK_HI) begin
			mask_q[63:32] <= reg_wdata;
		end else if (reg_wr && reg_addr == `IRMF_MASK_LO) begin
			mask_q[31:0] <= reg_wdata;
		end
	end

	// register read
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_ptr_ctx >= 0) begin
			rdata_d = ptr_q[rd_ptr_ctx]; // R01
		end else if (rd_match_ctx >= 0) begin
			rdata_d = match_q[rd_match_ctx] & `IRMF_MATCH_WMASK; // R03 R07
		end else if (rd_ctrl_ctx >= 0) begin
			rdata_d[`IRMF_CTRL_CME]    = cme_q[rd_ctrl_ctx];
			rdata_d[`IRMF_CTRL_MULTI]  = multi_q[rd_ctrl_ctx];
			rdata_d[`IRMF_CTRL_RUN]    = run_q[rd_ctrl_ctx];
			rdata_d[`IRMF_CTRL_ACTIVE] = ctx_active[rd_ctrl_ctx];
		end else if (reg_addr == `IRMF_MASK_HI) begin
			rdata_d = mask_q[63:32];
		end else if (reg_addr == `IRMF_MASK_LO) begin
			rdata_d = mask_q[31:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end else begin
			reg_rdata_q <= 32'h0000_0000;
		end
	end

	assign reg_rdata = reg_rdata_q;

	// lowest accepting context wins
	logic             hit;
	logic [CTX_W-1:0] hit_idx;

	always_comb begin
		hit     = 1'b0;
		hit_idx = '0;
		for (int i = CONTEXTS - 1; i >= 0; i--) begin
			if (accept[i]) begin
				hit     = 1'b1;
				hit_idx = CTX_W'(i);
			end
		end
	end

	// packet stream
	irmf_pkg::irmf_pkt_state_type state_q;
	logic [CTX_W-1:0]             ctx_q;
	logic                         f_in_ready;
	logic                         f_push;
	logic [CTX_W-1:0]             push_ctx;
	logic                         take;
	logic                         start_pass;

	assign start_pass = (state_q == irmf_pkg::IRMF_IDLE) && in_first && hit;
	assign push_ctx   = (state_q == irmf_pkg::IRMF_PASS) ? ctx_q : hit_idx;

	always_comb begin
		unique case (state_q)
			irmf_pkg::IRMF_IDLE: in_ready = start_pass ? f_in_ready : 1'b1;
			irmf_pkg::IRMF_PASS: in_ready = f_in_ready;
			irmf_pkg::IRMF_DROP: in_ready = 1'b1;
		endcase
	end

	assign take   = in_valid && in_ready;
	assign f_push = in_valid && f_in_ready && (start_pass || state_q == irmf_pkg::IRMF_PASS);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= irmf_pkg::IRMF_IDLE;
		end else if (take) begin
			unique case (state_q)
				irmf_pkg::IRMF_IDLE: begin
					if (!in_first || in_last) begin
						state_q <= irmf_pkg::IRMF_IDLE;
					end else if (hit) begin
						state_q <= irmf_pkg::IRMF_PASS;
					end else begin
						state_q <= irmf_pkg::IRMF_DROP;
					end
				end
				irmf_pkg::IRMF_PASS,
				irmf_pkg::IRMF_DROP: begin
					if (in_last) begin
						state_q <= irmf_pkg::IRMF_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctx_q <= '0;
		end else if (take && start_pass) begin
			ctx_q <= hit_idx;
		end
	end

	// one pulse per context when a sync-waiting packet is taken
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync_hit_q <= '0;
		end else begin
			for (int i = 0; i < CONTEXTS; i++) begin
				sync_hit_q[i] <= take && start_pass && hit_idx == CTX_W'(i)
					&& desc_wait_sync[i]; // R06
			end
		end
	end

	assign sync_hit = sync_hit_q;

	logic [FIFO_W-1:0] f_out_data;

	irmf_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   ({push_ctx, in_last, in_data}),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (f_out_data)
	);

	assign out_data = f_out_data[31:0];
	assign out_last = f_out_data[32];
	assign out_ctx  = f_out_data[FIFO_W-1:33];
endmodule

// [irmf_checker.sv]
module irmf_checker #(
	parameter int CONTEXTS   = 4,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic                ref_clk,
	input wire logic                rstn,
	input wire logic [15:0]         reg_addr,
	input wire logic [31:0]         reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [31:0]         reg_rdata,
	input wire logic [CONTEXTS-1:0] ptr_load,
	input wire logic [31:0]         ptr_load_value,
	input wire logic [CONTEXTS-1:0] desc_wait_sync,
	input wire logic                in_valid,
	input wire logic                in_ready,
	input wire logic                in_first,
	input wire logic                out_valid,
	input wire logic                out_ready,
	input wire logic [31:0]         out_data,
	input wire logic                out_last,
	input wire logic [CONTEXTS-1:0] ctx_active,
	input wire logic [CONTEXTS-1:0] sync_hit
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	a_rsvd_bits_zero: assert property ($past(reg_rd) && $past(reg_addr) == 16'h410c
		|-> reg_rdata[27:25] == 3'h0 && !reg_rdata[7])
		else $error("reserved match bits read nonzero");
	a_unmapped_read_zero: assert property ($past(reg_rd) && $past(reg_addr) == 16'h0004
		|-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_ptr_read_back: assert property (ptr_load[0] ##1 (reg_rd && reg_addr == 16'h040c)
		|=> reg_rdata == $past(ptr_load_value, 2))
		else $error("pointer read differs from loaded value");
	a_match_read_back: assert property (reg_wr && reg_addr == 16'h410c ##1
		reg_rd && reg_addr == 16'h410c |=> reg_rdata == ($past(reg_wdata, 2) & 32'hf1ff_ff7f))
		else $error("match read differs from written value");
	a_sync_hit_cause: assert property (sync_hit[0]
		|-> $past(in_valid && in_ready && in_first && desc_wait_sync[0]))
		else $error("sync hit without waiting first word");
	a_out_hold_stall: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_data) && $stable(out_last))
		else $error("output changed while stalled");
	a_idle_drop: assert property (in_valid && in_ready && in_first && ctx_active == '0
		&& !out_valid |=> !out_valid)
		else $error("packet passed with no context started");
	c_sync_hit: cover property (sync_hit[0]);
	c_fifo_full: cover property (out_valid && !out_ready && !in_ready);
	c_ctx_start: cover property ($rose(ctx_active[0]));
endmodule

bind irmf_filter irmf_checker #(.CONTEXTS(CONTEXTS), .FIFO_DEPTH(FIFO_DEPTH)) u_irmf_checker (
	.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ptr_load,
	.ptr_load_value, .desc_wait_sync, .in_valid, .in_ready, .in_first, .out_valid,
	.out_ready, .out_data, .out_last, .ctx_active, .sync_hit);

// [irmf_pkt_src.sv]
module irmf_pkt_src (
	input  wire logic        ref_clk,
	input  wire logic        in_ready,
	output logic             in_valid,
	output logic             in_first,
	output logic             in_last,
	output logic      [31:0] in_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		in_valid = 1'b0;
		in_first = 1'b0;
		in_last  = 1'b0;
		in_data  = 32'h0;
	end
	// words held until taken, data inverted once released
	task automatic send(input logic [31:0] hdr, input int len);
		for (int i = 0; i < len; i++) begin
			in_valid <= 1'b1;
			in_first <= i == 0;
			in_last  <= i == len - 1;
			in_data  <= (i == 0) ? hdr : hdr ^ 32'(i);
			do @(posedge ref_clk); while (!in_ready);
		end
		in_valid <= 1'b0;
		in_data  <= ~in_data;
	endtask
endmodule

// [tb_irmf_filter.sv]
module tb_irmf_filter;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, out_ready = 0;
	logic [15:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, ptr_load_value = 0, reg_rdata, in_data, out_data;
	logic [3:0]  ptr_load = 0, desc_wait_sync = 0, ctx_active, sync_hit;
	logic [6:0]  timer_seconds_field = 0;
	logic [12:0] timer_cycle_field = 0;
	logic        in_valid, in_ready, in_first, in_last, out_valid, out_last;
	logic [1:0]  out_ctx;
	int          n_fail = 0, compares = 0, n_out = 0, cyc = 0;
	logic [31:0] m, r, last_word = 0;
	logic [1:0]  last_ctx = 0;
	logic        last_last = 0;
	always @(posedge ref_clk) begin
		if (out_valid && out_ready) begin
			last_word <= out_data;
			last_ctx  <= out_ctx;
			last_last <= out_last;
		end
	end
	irmf_filter #(.CONTEXTS(4), .FIFO_DEPTH(16)) u_irmf_filter (
		.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ptr_load,
		.ptr_load_value, .desc_wait_sync, .timer_seconds_field, .timer_cycle_field,
		.in_valid, .in_ready, .in_first, .in_last, .in_data, .out_valid, .out_ready,
		.out_data, .out_last, .out_ctx, .ctx_active, .sync_hit);
	irmf_pkt_src u_irmf_pkt_src (.ref_clk, .in_ready, .in_valid, .in_first, .in_last, .in_data);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (out_valid && out_ready) n_out <= n_out + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
		@(posedge ref_clk);
	endtask
	function automatic logic acc(logic [31:0] m, logic [1:0] t, logic [5:0] c, logic [3:0] s);
		acc = m[28 + t] && c == m[5:0] && !(t == 2'h1 && m[6] && s[3:2] != 2'h0);
	endfunction
	task automatic pkt(input logic [1:0] t, input logic [5:0] c, input logic [3:0] s, input logic e);
		int n0;
		logic [31:0] h;
		n0 = n_out;
		h = {16'h0, t, c, 4'h0, s};
		u_irmf_pkt_src.send(h, 2);
		repeat (4) @(posedge ref_clk);
		chk(32'(n_out - n0), e ? 32'h2 : 32'h0);
		if (e) begin
			chk(last_word, h ^ 32'h1);
			chk(32'({last_ctx, last_last}), 32'h1);
		end
	endtask
	task automatic final_report();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(89));
		repeat (5) @(posedge ref_clk);
		rstn <= 1'b1;
		out_ready <= 1'b1;
		@(posedge ref_clk);
		for (int c = 0; c < 4; c++) begin
			r = (c == 0) ? 32'hffff_ffff : $urandom;
			wr(16'h410c + 16'(32 * c), r);
			rd(16'h410c + 16'(32 * c), r & 32'hf1ff_ff7f);
		end
		ptr_load <= 4'h1;
		ptr_load_value <= r;
		@(posedge ref_clk);
		ptr_load <= 4'h0;
		rd(16'h040c, r);
		wr(16'h040c, ~r);
		rd(16'h040c, r);
		rd(16'h0004, 32'h0);
		$display("test registers done");
		wr(16'h0400, 32'h0000_8000);
		for (int i = 0; i < 40; i++) begin
			m = $urandom & 32'hf000_0043;
			r = $urandom;
			wr(16'h410c, m);
			pkt(r[1:0], {4'h0, r[3:2]}, r[7:4], acc(m, r[1:0], {4'h0, r[3:2]}, r[7:4]));
		end
		wr(16'h410c, 32'h2000_0045);
		pkt(2'h1, 6'h05, 4'h3, 1'b1);
		pkt(2'h1, 6'h05, 4'h4, 1'b0);
		$display("test tag filter done");
		wr(16'h0400, 32'h0);
		wr(16'h0078, 32'h0000_0200);
		wr(16'h0070, 32'h0000_0001);
		wr(16'h0400, 32'h1000_8000);
		wr(16'h410c, 32'h1000_0005);
		pkt(2'h0, 6'h09, 4'h0, 1'b1);
		pkt(2'h0, 6'h20, 4'h0, 1'b1);
		pkt(2'h0, 6'h05, 4'h0, 1'b0);
		$display("test multi channel done");
		wr(16'h0400, 32'h0);
		wr(16'h410c, 32'h1012_3000);
		timer_cycle_field <= 13'h0122;
		wr(16'h0400, 32'h2000_8000);
		repeat (2) @(posedge ref_clk);
		chk(32'(ctx_active), 32'h0);
		pkt(2'h0, 6'h00, 4'h0, 1'b0);
		timer_cycle_field <= 13'h0123;
		@(posedge ref_clk);
		timer_cycle_field <= 13'h0124;
		repeat (2) @(posedge ref_clk);
		chk(32'(ctx_active), 32'h1);
		pkt(2'h0, 6'h00, 4'h0, 1'b1);
		$display("test cycle start done");
		wr(16'h0400, 32'h0);
		wr(16'h0400, 32'h0000_8000);
		wr(16'h410c, 32'h1000_0a00);
		desc_wait_sync <= 4'h1;
		pkt(2'h0, 6'h00, 4'h5, 1'b0);
		pkt(2'h0, 6'h00, 4'ha, 1'b1);
		desc_wait_sync <= 4'h0;
		$display("test sync done");
		out_ready <= 1'b0;
		r = n_out;
		fork
			u_irmf_pkt_src.send(32'h0000_0000, 20);
		join_none
		repeat (30) @(posedge ref_clk);
		chk(32'(in_ready), 32'h0);
		out_ready <= 1'b1;
		repeat (30) @(posedge ref_clk);
		chk(32'(n_out) - r, 32'd20);
		chk(32'(out_valid), 32'h0);
		$display("test buffer done");
		final_report();
	end
endmodule
